// [core/asm_regs.vh]
// Register map, field positions, field codes and reset value for the serial block
`ifndef ASM_REGS_VH
`define ASM_REGS_VH
`define ASM_RS_DATA       1'b1
`define ASM_RS_CTRLSTAT   1'b0
`define ASM_CR_DIV_LO     0
`define ASM_CR_DIV_HI     1
`define ASM_CR_WS_LO      2
`define ASM_CR_WS_HI      4
`define ASM_CR_TXC_LO     5
`define ASM_CR_TXC_HI     6
`define ASM_CR_RIE        7
`define ASM_DIV_X1        2'b00
`define ASM_DIV_X16       2'b01
`define ASM_DIV_X64       2'b10
`define ASM_DIV_MRESET    2'b11
`define ASM_TXC_BREAK     2'b11
`define ASM_TXC_RTS_HIGH  2'b10
`define ASM_TXC_TIE       2'b01
`define ASM_SR_RX_FULL_FLAG       0
`define ASM_SR_TX_EMPTY_FLAG       1
`define ASM_SR_DCD        2
`define ASM_SR_CTS        3
`define ASM_SR_FE         4
`define ASM_SR_OVERRUN_FLAG       5
`define ASM_SR_PE         6
`define ASM_SR_IRQ        7
`define ASM_CTRL_RESET    8'h03
`endif

// [core/asm_serial.v]
// Asynchronous serial interface with modem status and four registers
`timescale 1ns/1ps
`include "asm_regs.vh"
// Function
// - New transmit bits launch on falling transmit clock edge.
// - Receive data sampled on rising receive clock edge.
// - Clocks run at 1, 16 or 64 times the bit rate.
// - x16/x64 resynchronise internally; x1 needs externally aligned clock.
// - Serial data on both lines is NRZ.
// - Clear-to-send high forces transmit-empty low, status bit high.
// - Status bit 3 mirrors clear-to-send; master reset leaves it.
// - Request-to-send active low, set only by control register.
// - Carrier-detect high holds receiver disabled and initialised.
// - Carrier-detect rising raises interrupt when receive interrupt enabled.
// - Status bit 2 latches until status then data read, then follows.
// - Select and read/write decode transmit, receive, control, status.
// - Characters go least significant bit first, bit 0 first.
// - Unused received bits read zero; unused transmit bits ignored.
// - Status bit 0 sets on character transfer, clears on read.
// - Carrier-detect high makes receive-full read as empty.
// - Status bit 1 low from data write until transmission starts.
// - Framing error when first stop missing, updated at transfer.
// - Overrun at mid last bit; shown after prior character read.
// - Character sync kept in overrun; overrun cleared on data read.
// - Parity error when ones count disagrees, held with character.
// - No parity suppresses transmit parity and receive check.
// - Control bits 1..0 equal 11 apply master reset; else divide.
// - Control bits 4..2 select frame format, effective immediately.
// - Control bits 6..5 set request-to-send, transmit interrupt, break.
// - Control bit 7 enables receive-full and carrier-loss interrupts.
module asm_serial (
  // Clock and reset
  input  wire       mclk,
  input  wire       srst,
  // Processor bus
  input  wire       enable,
  input  wire       cs0,
  input  wire       cs1,
  input  wire       cs2_n,
  input  wire       register_select,
  input  wire       rw,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output wire       data_oe_n,
  output wire       irq_out,
  output wire       irq_oe_n,
  // Modem side
  input  wire       transmit_clock_in,
  input  wire       receive_clock_in,
  input  wire       rxd,
  output reg        txd,
  input  wire       cts_n,
  output wire       rts_n,
  input  wire       dcd_n
);
  wire       e_s;
  wire       txc_s;
  wire       rxc_s;
  wire       rxd_s;
  wire       cts_s;
  wire       dcd_s;
  // Synchronised bus pins
  wire       cs0_s;
  wire       cs1_s;
  wire       cs2_n_s;
  wire       rs_s;
  wire       rw_s;
  wire [7:0] din_s;
  reg        e_d_reg;
  reg        txc_d_reg;
  reg        rxc_d_reg;
  reg        dcd_d_reg;
  reg  [7:0] ctrl_reg;
  reg  [7:0] tdr_reg;
  reg        tx_empty_flag_reg;
  reg  [7:0] rdr_reg;
  reg        rx_full_flag_reg;
  reg        fe_reg;
  reg        pe_reg;
  reg        overrun_flag_pend_reg;
  reg        overrun_flag_reg;
  reg        dcd_latch_reg;
  reg        stat_read_reg;
  // Transmitter
  reg  [3:0] tx_bit_reg;
  reg  [5:0] tx_cnt_reg;
  reg [10:0] tx_sh_reg;
  reg  [3:0] tx_len_reg;
  reg        tx_busy_reg;
  // Receiver
  reg        rx_busy_reg;
  reg  [5:0] rx_cnt_reg;
  reg  [3:0] rx_bit_reg;
  reg  [9:0] rx_sh_reg;

  asm_sync u_e   (.mclk(mclk), .srst(srst), .din(enable),            .dout(e_s));
  asm_sync u_txc (.mclk(mclk), .srst(srst), .din(transmit_clock_in), .dout(txc_s));
  asm_sync u_rxc (.mclk(mclk), .srst(srst), .din(receive_clock_in),  .dout(rxc_s));
  asm_sync u_rxd (.mclk(mclk), .srst(srst), .din(rxd),               .dout(rxd_s));
  asm_sync u_cts (.mclk(mclk), .srst(srst), .din(cts_n),             .dout(cts_s));
  asm_sync u_dcd (.mclk(mclk), .srst(srst), .din(dcd_n),             .dout(dcd_s));

  // Bus pins come from the processor's timing, so they pass two flops too
  asm_sync u_cs0 (.mclk(mclk), .srst(srst), .din(cs0),               .dout(cs0_s));
  asm_sync u_cs1 (.mclk(mclk), .srst(srst), .din(cs1),               .dout(cs1_s));
  asm_sync u_cs2 (.mclk(mclk), .srst(srst), .din(cs2_n),             .dout(cs2_n_s));
  asm_sync u_rs  (.mclk(mclk), .srst(srst), .din(register_select),   .dout(rs_s));
  asm_sync u_rw  (.mclk(mclk), .srst(srst), .din(rw),                .dout(rw_s));

  // Write data, one synchroniser per bit; it is stable long before enable falls
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_din
      asm_sync u_din (.mclk(mclk), .srst(srst), .din(data_in[gi]), .dout(din_s[gi]));
    end
  endgenerate

  // Access decode, acting on the falling edge of enable
  wire       sel       = cs0_s & cs1_s & ~cs2_n_s;
  wire       e_fall    = e_d_reg & ~e_s;
  wire       acc       = sel & e_fall;
  wire       wr_tdr    = acc & rs_s & ~rw_s;
  wire       rd_rdr    = acc & rs_s & rw_s;
  wire       wr_ctrl   = acc & ~rs_s & ~rw_s;
  wire       rd_stat   = acc & ~rs_s & rw_s;
  wire       txc_fall  = txc_d_reg & ~txc_s;
  wire       rxc_rise  = rxc_s & ~rxc_d_reg;
  wire [1:0] div       = ctrl_reg[`ASM_CR_DIV_HI:`ASM_CR_DIV_LO];
  wire       mreset    = (div == `ASM_DIV_MRESET);
  wire [2:0] ws        = ctrl_reg[`ASM_CR_WS_HI:`ASM_CR_WS_LO];
  wire [1:0] txc       = ctrl_reg[`ASM_CR_TXC_HI:`ASM_CR_TXC_LO];
  wire       receive_interrupt_enable       = ctrl_reg[`ASM_CR_RIE];
  wire       len8      = ws[2];
  wire       par_en    = ~(ws[2] & ~ws[1]);
  wire       par_odd   = ws[0];
  wire       two_stop  = ~ws[1];
  wire [5:0] bit_top   = (div == `ASM_DIV_X64) ? 6'h3f :
                         (div == `ASM_DIV_X16) ? 6'h0f : 6'h00;
  wire [5:0] bit_mid   = {1'b0, bit_top[5:1]};
  wire       tx_tick   = txc_fall & (tx_cnt_reg == bit_top);
  wire       rx_tick   = rxc_rise & (rx_cnt_reg == bit_mid);
  wire [3:0] rx_last   = (len8 ? 4'h8 : 4'h7) + {3'h0, par_en};
  wire [7:0] tx_data   = len8 ? tdr_reg : {1'b0, tdr_reg[6:0]};
  wire       tx_par    = (^tx_data) ^ par_odd;

  always @(posedge mclk) begin
    if (srst) begin
      e_d_reg   <= 1'b0;
      txc_d_reg <= 1'b0;
      rxc_d_reg <= 1'b0;
      dcd_d_reg <= 1'b0;
    end else begin
      e_d_reg   <= e_s;
      txc_d_reg <= txc_s;
      rxc_d_reg <= rxc_s;
      dcd_d_reg <= dcd_s;
    end
  end

  // Control register
  always @(posedge mclk) begin
    if (srst) begin
      ctrl_reg <= `ASM_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= din_s;
    end
  end

  // Transmit data register and empty flag
  always @(posedge mclk) begin
    if (srst || mreset) begin
      tdr_reg  <= 8'h00;
      tx_empty_flag_reg <= 1'b1;
    end else if (wr_tdr) begin
      tdr_reg  <= din_s;
      tx_empty_flag_reg <= 1'b0;
    end else if (!tx_empty_flag_reg && tx_tick &&
                 !(tx_busy_reg && tx_bit_reg != tx_len_reg)) begin
      // Empty again as soon as the shifter takes the character
      tx_empty_flag_reg <= 1'b1;
    end
  end

  // Transmitter shifter, bits leave on falling clock edges
  always @(posedge mclk) begin
    if (srst || mreset) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg  <= 6'h00;
      tx_bit_reg  <= 4'h0;
      tx_sh_reg   <= 11'h7ff;
      tx_len_reg  <= 4'h0;
      txd         <= 1'b1;
    end else begin
      if (txc_fall) begin
        tx_cnt_reg <= (tx_cnt_reg == bit_top) ? 6'h00 : tx_cnt_reg + 6'h01;
      end
      if (tx_tick) begin
        if (tx_busy_reg && tx_bit_reg != tx_len_reg) begin
          txd        <= tx_sh_reg[0];
          tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
          tx_bit_reg <= tx_bit_reg + 4'h1;
        end else if (!tx_empty_flag_reg) begin
          txd         <= 1'b0;
          tx_busy_reg <= 1'b1;
          tx_bit_reg  <= 4'h0;
          if (len8) begin
            tx_sh_reg  <= {2'b11, par_en ? tx_par : 1'b1, tx_data};
            // Shifts after the start bit: data, parity, stop bits
            tx_len_reg <= 4'h9 + {3'h0, par_en} + {3'h0, two_stop};
          end else begin
            tx_sh_reg  <= {3'b111, tx_par, tx_data[6:0]};
            tx_len_reg <= 4'h9 + {3'h0, two_stop};
          end
        end else begin
          tx_busy_reg <= 1'b0;
          txd         <= (txc == `ASM_TXC_BREAK) ? 1'b0 : 1'b1;
        end
      end
    end
  end

  // Receiver: start detect, mid-bit sampling, transfer to data register
  // The stop bit is the sample taken at the finishing tick
  wire       rx_stop  = rxd_s;
  wire       rx_done  = rx_busy_reg & rx_tick & (rx_bit_reg == rx_last + 4'h1);
  wire       dcd_rise = dcd_s & ~dcd_d_reg;

  always @(posedge mclk) begin
    if (srst || mreset || dcd_s) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg  <= 6'h00;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 10'h000;
    end else if (rxc_rise) begin
      if (!rx_busy_reg) begin
        rx_cnt_reg <= 6'h00;
        if (!rxd_s) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= (bit_top == 6'h00) ? 6'h00 : 6'h01;
          rx_bit_reg  <= 4'h1;
        end
      end else begin
        rx_cnt_reg <= (rx_cnt_reg == bit_top) ? 6'h00 : rx_cnt_reg + 6'h01;
        if (rx_tick) begin
          if (rx_done) begin
            rx_busy_reg <= 1'b0;
            rx_bit_reg  <= 4'h0;
          end else begin
            rx_sh_reg  <= {rxd_s, rx_sh_reg[9:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
          end
        end
      end
    end
  end

  // Received data aligned to low bits
  // rx_last bits entered from the top of a ten-bit shifter
  wire [9:0] rx_al = rx_sh_reg >> (4'ha - rx_last);
  wire [7:0] rx_dat = len8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
  wire       rx_par = len8 ? rx_al[8] : rx_al[7];
  wire       rx_perr = par_en & (((^rx_dat) ^ rx_par) != par_odd);

  // Receive data register and error flags
  always @(posedge mclk) begin
    if (srst || mreset) begin
      rdr_reg       <= 8'h00;
      rx_full_flag_reg      <= 1'b0;
      fe_reg        <= 1'b0;
      pe_reg        <= 1'b0;
      overrun_flag_pend_reg <= 1'b0;
      overrun_flag_reg      <= 1'b0;
    end else begin
      if (rd_rdr) begin
        if (overrun_flag_pend_reg) begin
          overrun_flag_reg      <= 1'b1;
          overrun_flag_pend_reg <= 1'b0;
        end else begin
          overrun_flag_reg <= 1'b0;
          rx_full_flag_reg <= 1'b0;
        end
      end
      if (rx_done) begin
        if (!rx_full_flag_reg || (rd_rdr && !overrun_flag_pend_reg)) begin
          rdr_reg  <= rx_dat;
          rx_full_flag_reg <= 1'b1;
          fe_reg   <= ~rx_stop;
          pe_reg   <= rx_perr;
        end else begin
          overrun_flag_pend_reg <= 1'b1;
        end
      end
    end
  end

  // Carrier-loss latch, cleared by status read followed by data read
  always @(posedge mclk) begin
    if (srst || mreset) begin
      dcd_latch_reg <= 1'b0;
      stat_read_reg <= 1'b0;
    end else begin
      if (dcd_rise) begin
        dcd_latch_reg <= 1'b1;
        stat_read_reg <= 1'b0;
      end else if (rd_stat && dcd_latch_reg) begin
        stat_read_reg <= 1'b1;
      end else if (rd_rdr && stat_read_reg) begin
        dcd_latch_reg <= 1'b0;
        stat_read_reg <= 1'b0;
      end
    end
  end

  wire st_rx_full_flag = rx_full_flag_reg & ~dcd_s;
  wire st_tx_empty_flag = tx_empty_flag_reg & ~cts_s;
  wire st_dcd  = dcd_latch_reg | dcd_s;
  wire irq_rx  = receive_interrupt_enable & (st_rx_full_flag | overrun_flag_reg | dcd_latch_reg);
  wire irq_tx  = (txc == `ASM_TXC_TIE) & st_tx_empty_flag;
  wire irq     = irq_rx | irq_tx;
  wire [7:0] status = {irq, pe_reg, overrun_flag_reg, fe_reg,
                       cts_s, st_dcd, st_tx_empty_flag, st_rx_full_flag};

  // Read data, driven while enable is high on a read
  always @(posedge mclk) begin
    if (srst) begin
      data_out <= 8'h00;
    end else if (sel && e_s && rw_s) begin
      data_out <= rs_s ? rdr_reg : status;
    end
  end

  // Pin drivers
  assign data_oe_n = ~(sel & e_s & rw_s);
  assign irq_out   = 1'b0;
  assign irq_oe_n  = ~irq;
  assign rts_n     = (txc == `ASM_TXC_RTS_HIGH);
endmodule

// [core/asm_sync.v]
// Two-flop synchroniser for one asynchronous input
`timescale 1ns/1ps
module asm_sync (
  // Clock and reset
  input  wire mclk,
  input  wire srst,
  // Async in, synchronised out
  input  wire din,
  output wire dout
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge mclk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end
  assign dout = sync_reg;
endmodule

// [tb/asm_modem.sv]
// Modem model: free-running link clock, serial sender and frame catcher
`timescale 1ns/1ps
module asm_modem (
  // Link
  output logic      link_clk,
  output logic      rxd,
  input  wire logic txd
);
  initial begin
    link_clk = 1'b0;
    rxd = 1'b1;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  // Bits leave LSB first, changed at falling clock so the rising edge sees them settled
  task send(input logic [10:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge link_clk);
      rxd = b[i];
    end
    @(negedge link_clk);
    rxd = 1'b1;
  endtask
  // Catch start plus nine bits at rising clock
  task grab(output logic [9:0] f);
    @(posedge link_clk iff txd === 1'b0);
    f[0] = 1'b0;
    for (int i = 1; i < 10; i++) begin
      @(posedge link_clk);
      f[i] = txd;
    end
  endtask
endmodule

// [tb/asm_serial_monitor.sv]
// Port-level concurrent checks for the serial block
`timescale 1ns/1ps
module asm_serial_monitor (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       srst,
  // Processor bus
  input wire logic       enable,
  input wire logic       cs0,
  input wire logic       cs1,
  input wire logic       cs2_n,
  input wire logic       register_select,
  input wire logic       rw,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n,
  input wire logic       irq_oe_n,
  // Modem side
  input wire logic       transmit_clock_in,
  input wire logic       txd,
  input wire logic       cts_n,
  input wire logic       rts_n,
  input wire logic       dcd_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Status read that has been driven for two cycles
  sequence s_stat;
    !data_oe_n && $past(!data_oe_n) && !register_select;
  endsequence
  property p_oe_sel; !data_oe_n |-> rw && cs0 && cs1 && !cs2_n; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("bus driven unselected");
  property p_oe_fast; $rose(enable) && rw && cs0 && cs1 && !cs2_n |-> ##[1:4] !data_oe_n;
  endproperty
  a_oe_fast: assert property (p_oe_fast) else $error("read not driven");
  property p_txd_fall; $changed(txd) |-> !transmit_clock_in; endproperty
  a_txd_fall: assert property (p_txd_fall) else $error("txd moved, clock high");
  property p_cts_hi; s_stat ##0 (cts_n && $past(cts_n, 6)) |-> data_out[3] && !data_out[1];
  endproperty
  a_cts_hi: assert property (p_cts_hi) else $error("cts high status wrong");
  property p_cts_lo; s_stat ##0 (!cts_n && !$past(cts_n, 6)) |-> !data_out[3]; endproperty
  a_cts_lo: assert property (p_cts_lo) else $error("cts low status wrong");
  property p_irq_bit;
    s_stat ##0 ($stable(irq_oe_n) && $past(irq_oe_n) == $past(irq_oe_n, 2))
      |-> data_out[7] == !irq_oe_n;
  endproperty
  a_irq_bit: assert property (p_irq_bit) else $error("irq bit differs from pin");
  property p_dcd_bit; s_stat ##0 (dcd_n && $past(dcd_n, 6)) |-> data_out[2]; endproperty
  a_dcd_bit: assert property (p_dcd_bit) else $error("carrier bit low");
  property p_rx_full_flag_dcd; s_stat ##0 (dcd_n && $past(dcd_n, 6)) |-> !data_out[0]; endproperty
  a_rx_full_flag_dcd: assert property (p_rx_full_flag_dcd) else $error("full with no carrier");
  property p_rts; $changed(rts_n) |-> !rw && !register_select; endproperty
  a_rts: assert property (p_rts) else $error("rts moved without control write");
  c_dcd: cover property (s_stat ##0 dcd_n);
  c_txd: cover property ($fell(txd));
  c_rts: cover property ($rose(rts_n));
endmodule

bind asm_serial asm_serial_monitor u_asm_serial_monitor (
  .mclk, .srst, .enable, .cs0, .cs1, .cs2_n, .register_select, .rw, .data_out,
  .data_oe_n, .irq_oe_n, .transmit_clock_in, .txd, .cts_n, .rts_n, .dcd_n);

// [tb/asm_serial_test.sv]
// Self-checking bench for the serial block
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module asm_serial_test;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       enable = 1'b0;
  logic       cs0 = 1'b0;
  logic       cs1 = 1'b0;
  logic       cs2_n = 1'b1;
  logic       register_select = 1'b0;
  logic       rw = 1'b1;
  logic       cts_n = 1'b0;
  logic       dcd_n = 1'b0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] rd;
  wire  [7:0] data_out;
  wire        data_oe_n, irq_out, irq_oe_n, txd, rts_n, link_clk, rxd;
  int         failures = 0;
  int         tests_run = 0;
  asm_serial u_asm_serial (.mclk(mclk), .srst(srst), .enable(enable), .cs0(cs0), .cs1(cs1),
    .cs2_n(cs2_n), .register_select(register_select), .rw(rw), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .transmit_clock_in(link_clk), .receive_clock_in(link_clk), .rxd(rxd), .txd(txd),
    .cts_n(cts_n), .rts_n(rts_n), .dcd_n(dcd_n));
  asm_modem u_asm_modem (.link_clk(link_clk), .rxd(rxd), .txd(txd));
  initial forever #2 mclk = ~mclk;
  task results;
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One bus cycle: address set up, enable pulse, address held past the fall
  task bus(input logic rs, input logic r, input logic [7:0] wd);
    @(negedge mclk);
    {cs0, cs1, cs2_n, register_select, rw, data_in} = {3'b110, rs, r, wd};
    wt(2);
    enable = 1'b1;
    wt(8);
    rd = data_out;
    enable = 1'b0;
    wt(8);
    {cs0, rw} = 2'b01;
  endtask
  task wr(input logic rs, input logic [7:0] d);
    bus(rs, 1'b0, d);
  endtask
  task rchk(input logic rs, input logic [7:0] m, input logic [7:0] e, input string n);
    bus(rs, 1'b1, 8'h00);
    `CHK(n, e, rd & m)
  endtask
  task rx(input logic [10:0] b, input logic [7:0] m, e, d, input string s);
    u_asm_modem.send(b, 10);
    wt(10);
    rchk(1'b0, m, e, s);
    rchk(1'b1, 8'hff, d, s);
  endtask
  task t_ctrl;
    rchk(1'b0, 8'h8b, 8'h02, "reset status");
    wr(1'b0, 8'h03);
    wr(1'b0, 8'h14);
    `CHK("rts 00", 1'b0, rts_n)
    wr(1'b0, 8'h54);
    `CHK("rts 10", 1'b1, rts_n)
    wr(1'b0, 8'h34);
    `CHK("tx irq", 1'b0, irq_oe_n)
    rchk(1'b0, 8'h82, 8'h82, "irq bit");
    wr(1'b0, 8'h74);
    wt(40);
    `CHK("break", 1'b0, txd)
    `CHK("rts 11", 1'b0, rts_n)
    wr(1'b0, 8'h14);
    wt(40);
    `CHK("idle", 1'b1, txd)
  endtask
  task t_tx;
    logic [9:0] f, g;
    fork
      begin
        u_asm_modem.grab(f);
        u_asm_modem.grab(g);
      end
      begin
        wr(1'b1, 8'ha5);
        wt(40);
        wr(1'b1, 8'h3c);
        rchk(1'b0, 8'h02, 8'h00, "tx_empty_flag full");
      end
    join
    `CHK("frame 1", {1'b1, 8'ha5, 1'b0}, f)
    `CHK("frame 2", {1'b1, 8'h3c, 1'b0}, g)
    wt(40);
    rchk(1'b0, 8'h02, 8'h02, "tx_empty_flag empty");
  endtask
  task t_rx;
    rx({1'b1, 8'h3c, 1'b0}, 8'h51, 8'h01, 8'h3c, "rx 8n1");
    rchk(1'b0, 8'h01, 8'h00, "rx_full_flag clear");
    wr(1'b0, 8'h08);
    rx({1'b1, 1'b1, 7'h55, 1'b0}, 8'h51, 8'h41, 8'h55, "parity");
    wr(1'b0, 8'h14);
    rx({1'b0, 8'h81, 1'b0}, 8'h51, 8'h11, 8'h81, "framing");
  endtask
  task t_ovr;
    u_asm_modem.send({1'b1, 8'h11, 1'b0}, 10);
    u_asm_modem.send({1'b1, 8'h22, 1'b0}, 10);
    wt(10);
    rchk(1'b0, 8'h21, 8'h01, "ovr hidden");
    rchk(1'b1, 8'hff, 8'h11, "ovr first");
    rchk(1'b0, 8'h21, 8'h21, "ovr shown");
    cts_n = 1'b1;
    wr(1'b0, 8'h03);
    rchk(1'b0, 8'h2b, 8'h08, "mreset");
    cts_n = 1'b0;
    wr(1'b0, 8'h94);
  endtask
  task t_dcd;
    dcd_n = 1'b1;
    u_asm_modem.send({1'b1, 8'h5a, 1'b0}, 10);
    `CHK("carrier irq", 1'b0, irq_oe_n)
    rchk(1'b0, 8'h85, 8'h84, "carrier lost");
    bus(1'b1, 1'b1, 8'h00);
    rchk(1'b0, 8'h04, 8'h04, "carrier follows");
    dcd_n = 1'b0;
    wt(10);
    rchk(1'b0, 8'h04, 8'h00, "carrier back");
    bus(1'b1, 1'b1, 8'h00);
    `CHK("irq off", 1'b1, irq_oe_n)
    wr(1'b0, 8'h14);
    dcd_n = 1'b1;
    wt(10);
    `CHK("irq masked", 1'b1, irq_oe_n)
    dcd_n = 1'b0;
    wt(10);
  endtask
  initial begin
    wt(5);
    srst = 1'b0;
    wt(4);
    t_ctrl;
    t_tx;
    t_rx;
    t_ovr;
    t_dcd;
    results;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    results;
  end
endmodule
